// File: design/fabric_mux_wait.sv
// Purpose: Datapath steering, stall sequencing and read pipeline control for the fabric
// Assumes: External arbiter and address decoder supply grant and slave select
// Notes: Port properties come from the package
// Function
// RULE1: Write data goes from the granted master to its slave and read data returns to the requester.
// RULE2: Each master port has its own return multiplexer.
// RULE3: A slave that cannot answer in one cycle stretches the transfer while the master waits.
// RULE4: Slave setup and hold needs add stall cycles around the read and write strobes.
// RULE5: A small state machine per slave turns slave-side sequencing into master-side stalls.
// RULE6: A master stays stalled until the arbiter grants it the targeted slave.
// RULE7: A pipelined master may issue reads back to back with earlier reads still outstanding.
// RULE8: Read data reaches each master in the order that master issued its reads.
// RULE9: No latency tracking exists for a pair where neither side is pipelined.
// RULE10: A non-pipelined master reading a pipelined slave is stalled until its data returns.
// RULE11: While such a master waits, the slave is free to take transfers from other masters.
// RULE12: A pipelined master reading a non-pipelined slave is stalled until the data returns.
// RULE13: With a fixed-latency slave the master samples data exactly when it is valid.
// RULE14: With a variable-latency slave data is captured whenever the slave flags it valid.
// RULE15: Each master records the slave of every outstanding read to route and order returns.
`timescale 1ns/100ps
module fabric_mux_wait (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Master ports
	input wire logic [fabric_pkg::NM-1:0] m_read,
	input wire logic [fabric_pkg::NM-1:0] m_write,
	input wire logic [fabric_pkg::NM-1:0][fabric_pkg::IDW-1:0] m_sel,
	input wire logic [fabric_pkg::NM-1:0][fabric_pkg::DW-1:0] m_writedata,
	output logic [fabric_pkg::NM-1:0] m_waitrequest,
	output logic [fabric_pkg::NM-1:0][fabric_pkg::DW-1:0] m_readdata,
	output logic [fabric_pkg::NM-1:0] m_readdatavalid,
	// Arbiter grants
	input wire logic [fabric_pkg::NS-1:0] gnt_valid,
	input wire logic [fabric_pkg::NS-1:0][fabric_pkg::IDW-1:0] gnt_master,
	// Slave ports
	output logic [fabric_pkg::NS-1:0] s_read,
	output logic [fabric_pkg::NS-1:0] s_write,
	output logic [fabric_pkg::NS-1:0][fabric_pkg::DW-1:0] s_writedata,
	input wire logic [fabric_pkg::NS-1:0] s_waitrequest,
	input wire logic [fabric_pkg::NS-1:0][fabric_pkg::DW-1:0] s_readdata,
	input wire logic [fabric_pkg::NS-1:0] s_readdatavalid
);
	import fabric_pkg::*;

	typedef struct packed {
		phase_e [NS-1:0] phase;
		logic [NS-1:0][CW-1:0] cnt;
		logic [NS-1:0][IDW-1:0] owner;
		logic [NS-1:0] is_rd;
		logic [NS-1:0] s_rd;
		logic [NS-1:0] s_wr;
		logic [NS-1:0][DW-1:0] s_wdata;
		logic [NS-1:0][PIPE_LEN-1:0] pipe;
		logic [NM-1:0] busy;
		logic [NM-1:0] m_wait;
		logic [NM-1:0] m_rvalid;
		logic [NM-1:0][DW-1:0] m_rdata;
		logic [NM-1:0][IDW-1:0] last_sel;
	} fab_s;

	fab_s r;
	fab_s n;

	logic [NS-1:0] s_push;
	logic [NS-1:0] s_pop;
	logic [NS-1:0][IDW-1:0] s_head;
	logic [NS-1:0] s_empty;
	logic [NS-1:0] s_full;
	logic [NM-1:0] mq_push;
	logic [NM-1:0] mq_pop;
	logic [NM-1:0][IDW-1:0] mq_din;
	logic [NM-1:0] mq_empty;
	logic [NM-1:0] mq_full;

	// Admission check for a granted request
	function automatic logic start_ok(input logic rd, input logic wr, input logic hit,
		input logic s_pipe, input logic sq_full, input logic mfull, input logic mempty,
		input logic same_last);
		if (!(rd || wr) || !hit) begin
			return 1'b0;
		end
		if (!rd) begin
			return 1'b1;
		end
		if (s_pipe) begin
			return !sq_full && !mfull && (mempty || same_last);
		end
		return mempty;
	endfunction

	// Per-slave tag queues: which master owns each outstanding read
	for (genvar gs = 0; gs < NS; gs++) begin : g_slave_q
		// RULE9 only pipelined slaves
		if (S_PIPELINED[gs]) begin : g_q
			read_tag_fifo #(.W(IDW), .D(TAG_DEPTH)) u_q (
				.sys_clk(sys_clk),
				.rst(rst),
				.push(s_push[gs]),
				.din(r.owner[gs]),
				.pop(s_pop[gs]),
				.dout(s_head[gs]),
				.empty(s_empty[gs]),
				.full(s_full[gs])
			);
		end else begin : g_none
			assign s_head[gs] = '0;
			assign s_empty[gs] = 1'b1;
			assign s_full[gs] = 1'b0;
		end
	end

	// RULE15 per-master record of targeted slaves
	for (genvar gm = 0; gm < NM; gm++) begin : g_master_q
		// RULE9 no queue without any pipelined slave
		if (|S_PIPELINED) begin : g_q
			read_tag_fifo #(.W(IDW), .D(TAG_DEPTH)) u_q (
				.sys_clk(sys_clk),
				.rst(rst),
				.push(mq_push[gm]),
				.din(mq_din[gm]),
				.pop(mq_pop[gm]),
				.dout(),
				.empty(mq_empty[gm]),
				.full(mq_full[gm])
			);
		end else begin : g_none
			assign mq_empty[gm] = 1'b1;
			assign mq_full[gm] = 1'b0;
		end
	end

	always_comb begin
		logic [IDW-1:0] m;
		logic accept;
		logic done;
		logic rv;
		m = '0;
		accept = 1'b0;
		done = 1'b0;
		rv = 1'b0;
		n = r;
		n.m_wait = '1;
		n.m_rvalid = '0;
		s_push = '0;
		s_pop = '0;
		mq_push = '0;
		mq_pop = '0;
		mq_din = '0;
		for (int s = 0; s < NS; s++) begin
			// RULE5 slave-side sequencer
			accept = (r.phase[s] == PH_STROBE) && !s_waitrequest[s];
			done = 1'b0;
			unique case (r.phase[s])
				PH_IDLE: begin
					m = gnt_master[s];
					// RULE6 wait for grant
					if (gnt_valid[s] && r.m_wait[m] && !r.busy[m] && !n.busy[m] &&
						start_ok(m_read[m], m_write[m], m_sel[m] == IDW'(s), S_PIPELINED[s],
						s_full[s], mq_full[m], mq_empty[m], r.last_sel[m] == IDW'(s))) begin
						n.owner[s] = m;
						n.is_rd[s] = m_read[m];
						// RULE1 write data from granted master
						n.s_wdata[s] = m_writedata[m];
						n.busy[m] = 1'b1;
						// RULE4 setup stall
						if (S_SETUP[s] != '0) begin
							n.phase[s] = PH_SETUP;
							n.cnt[s] = CW'(S_SETUP[s] - 2'h1);
						end else begin
							n.phase[s] = PH_STROBE;
							n.s_rd[s] = m_read[m];
							n.s_wr[s] = !m_read[m];
						end
					end
				end
				PH_SETUP: begin
					if (r.cnt[s] == '0) begin
						n.phase[s] = PH_STROBE;
						n.s_rd[s] = r.is_rd[s];
						n.s_wr[s] = !r.is_rd[s];
					end else begin
						n.cnt[s] = CW'(r.cnt[s] - 2'h1);
					end
				end
				PH_STROBE: begin
					// RULE3 stretch while slave stalls
					if (accept) begin
						n.s_rd[s] = 1'b0;
						n.s_wr[s] = 1'b0;
						if (r.is_rd[s] && !S_PIPELINED[s]) begin
							n.m_rdata[r.owner[s]] = s_readdata[s];
						end
						if (r.is_rd[s] && S_PIPELINED[s]) begin
							s_push[s] = 1'b1;
							mq_push[r.owner[s]] = 1'b1;
							mq_din[r.owner[s]] = IDW'(s);
							n.last_sel[r.owner[s]] = IDW'(s);
						end
						// RULE4 hold stall
						if (S_HOLD[s] != '0) begin
							n.phase[s] = PH_HOLD;
							n.cnt[s] = CW'(S_HOLD[s] - 2'h1);
						end else begin
							n.phase[s] = PH_IDLE;
							done = 1'b1;
						end
					end
				end
				PH_HOLD: begin
					if (r.cnt[s] == '0) begin
						n.phase[s] = PH_IDLE;
						done = 1'b1;
					end else begin
						n.cnt[s] = CW'(r.cnt[s] - 2'h1);
					end
				end
			endcase
			// RULE11 slave freed once a pipelined read is handed off
			if (done) begin
				m = r.owner[s];
				// RULE10 non-pipelined master keeps waiting for data
				if (!(r.is_rd[s] && S_PIPELINED[s] && !M_PIPELINED[m])) begin
					// RULE7 pipelined master released when the strobe and any hold cycles end
					n.m_wait[m] = 1'b0;
					n.busy[m] = 1'b0;
					// RULE12 unpipelined slave answers with its data
					if (r.is_rd[s] && !S_PIPELINED[s]) begin
						n.m_rvalid[m] = M_PIPELINED[m];
					end
				end
			end
			// RULE13 fixed latency timing line
			n.pipe[s] = {r.pipe[s][PIPE_LEN-2:0], accept && r.is_rd[s] && S_PIPELINED[s]};
			// RULE14 variable latency valid flag
			rv = S_VARIABLE[s] ? s_readdatavalid[s] : r.pipe[s][S_LATENCY[s] - 2'h1];
			// RULE8 return goes to the oldest requester of this slave
			if (S_PIPELINED[s] && rv && !s_empty[s]) begin
				m = s_head[s];
				s_pop[s] = 1'b1;
				mq_pop[m] = 1'b1;
				// RULE1 read data back to requester
				n.m_rdata[m] = s_readdata[s];
				if (M_PIPELINED[m]) begin
					n.m_rvalid[m] = 1'b1;
				end else begin
					// RULE10 release with data
					n.m_wait[m] = 1'b0;
					n.busy[m] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.m_wait <= '1;
		end else begin
			r <= n;
		end
	end

	// RULE2 per-master return registers
	assign m_waitrequest = r.m_wait;
	assign m_readdata = r.m_rdata;
	assign m_readdatavalid = r.m_rvalid;
	assign s_read = r.s_rd;
	assign s_write = r.s_wr;
	assign s_writedata = r.s_wdata;
endmodule // fabric_mux_wait

// File: shared/fabric_pkg.sv
// Purpose: Shared constants and types for the fabric datapath, stall and pipeline logic
// Assumes: Two master ports and two slave ports, 32-bit data
// Notes: Port properties are fixed here; one set of constants shapes the generated logic
package fabric_pkg;
	localparam int NM = 2;
	localparam int NS = 2;
	localparam int IDW = 1;
	localparam int DW = 32;
	localparam int CW = 2;
	localparam int TAG_DEPTH = 4;
	localparam int PIPE_LEN = 4;
	// Master 1 is pipelined, master 0 is not
	localparam logic [NM-1:0] M_PIPELINED = 2'h2;
	// Both slaves pipelined; slave 1 variable latency, slave 0 fixed latency
	localparam logic [NS-1:0] S_PIPELINED = 2'h3;
	localparam logic [NS-1:0] S_VARIABLE = 2'h2;
	localparam logic [NS-1:0][CW-1:0] S_LATENCY = {2'h0, 2'h2};
	// Strobe setup and hold cycles per slave
	localparam logic [NS-1:0][CW-1:0] S_SETUP = {2'h1, 2'h0};
	localparam logic [NS-1:0][CW-1:0] S_HOLD = {2'h0, 2'h1};
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_SETUP = 2'b01,
		PH_STROBE = 2'b10,
		PH_HOLD = 2'b11
	} phase_e;
endpackage

// File: design/read_tag_fifo.sv
// Purpose: Small in-order tag memory for outstanding reads
// Assumes: Push and pop never exceed full or empty; both are guarded inside
// Notes: Head of queue comes out of a register
`timescale 1ns/100ps
module read_tag_fifo #(
	parameter int W = 1,
	parameter int D = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Write side
	input wire logic push,
	input wire logic [W-1:0] din,
	// Read side
	input wire logic pop,
	output logic [W-1:0] dout,
	output logic empty,
	output logic full
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
		logic [W-1:0] head;
	} tag_s;

	tag_s r;
	tag_s n;
	logic do_push;
	logic do_pop;

	assign empty = (r.cnt == '0);
	assign full = (r.cnt == (AW+1)'(D));
	assign dout = r.head;
	assign do_push = push && !full;
	assign do_pop = pop && !empty;

	// Next state of pointers, count and head register
	always_comb begin
		n = r;
		if (do_push) begin
			n.mem[r.wr] = din;
			n.wr = AW'(r.wr + 1'b1);
		end
		if (do_pop) begin
			n.rd = AW'(r.rd + 1'b1);
		end
		n.cnt = (AW+1)'(r.cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop});
		if (do_push && ((AW+1)'(r.cnt - {{AW{1'b0}}, do_pop}) == '0)) begin
			n.head = din;
		end else begin
			n.head = r.mem[n.rd];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule // read_tag_fifo

// File: tb/fabric_mux_wait_monitor.sv
// Purpose: Port checker for fabric_mux_wait
// Assumes: Master 0 reads slave 0 only; slave 1 is read by master 1 only
// Notes: Bound to every instance of the design
`timescale 1ns/100ps
module fabric_mux_wait_monitor import fabric_pkg::*; (
	// Clock and reset
	input logic sys_clk,
	input logic rst,
	// Masters
	input logic [NM-1:0] m_read,
	input logic [NM-1:0] m_write,
	input logic [NM-1:0][IDW-1:0] m_sel,
	input logic [NM-1:0][DW-1:0] m_writedata,
	input logic [NM-1:0] m_waitrequest,
	input logic [NM-1:0][DW-1:0] m_readdata,
	input logic [NM-1:0] m_readdatavalid,
	// Grants
	input logic [NS-1:0] gnt_valid,
	input logic [NS-1:0][IDW-1:0] gnt_master,
	// Slaves
	input logic [NS-1:0] s_read,
	input logic [NS-1:0] s_write,
	input logic [NS-1:0][DW-1:0] s_writedata,
	input logic [NS-1:0] s_waitrequest,
	input logic [NS-1:0][DW-1:0] s_readdata,
	input logic [NS-1:0] s_readdatavalid
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_WAIT_ONE: assert property ((m_waitrequest != 2'h3) |=>
		(m_waitrequest | $past(m_waitrequest)) == 2'h3) else $error("wait low twice");
	AST_DONE_NEEDS_REQ: assert property (((~m_waitrequest) & ~(m_read | m_write)) == 2'h0)
		else $error("done without request");
	AST_HOLD_S0: assert property ((s_read[0] || s_write[0]) && !s_waitrequest[0] |=>
		!(s_read[0] || s_write[0]) [*2]) else $error("no hold cycle");
	AST_SETUP_S1: assert property ($rose(s_read[1] || s_write[1]) |->
		$past(gnt_valid[1], 2)) else $error("no setup cycle");
	AST_FIXED_LAT: assert property (s_read[0] && !s_waitrequest[0] && gnt_master[0] == 1'b1
		|-> ##3 m_readdatavalid[1] && m_readdata[1] == $past(s_readdata[0])) else $error("fixed lat");
	AST_VAR_CAPTURE: assert property (s_readdatavalid[1] |=> m_readdatavalid[1] &&
		m_readdata[1] == $past(s_readdata[1])) else $error("valid not passed on");
	AST_NP_WAIT: assert property (!m_waitrequest[0] && m_read[0] |-> $past(s_read[0], 3) &&
		!$past(s_waitrequest[0], 3) && m_readdata[0] == $past(s_readdata[0])) else $error("np read");
	AST_WR_ROUTE: assert property (s_write[1] |-> s_writedata[1] == m_writedata[gnt_master[1]])
		else $error("write data route");
endmodule // fabric_mux_wait_monitor
bind fabric_mux_wait fabric_mux_wait_monitor u_mon (.*);

// File: tb/slave_model.sv
// Purpose: Behavioural slaves for the fabric bench
// Assumes: Slave 0 fixed latency 2, slave 1 variable latency
// Notes: Stalls every other cycle while slow is set
`timescale 1ns/100ps
module slave_model import fabric_pkg::*; (
	// Control
	input logic sys_clk,
	input logic rst,
	input logic slow,
	// Slave ports
	input logic [NS-1:0] s_read,
	input logic [NS-1:0] s_write,
	input logic [NS-1:0][DW-1:0] s_writedata,
	output logic [NS-1:0] s_waitrequest,
	output logic [NS-1:0][DW-1:0] s_readdata,
	output logic [NS-1:0] s_readdatavalid,
	output logic [NS-1:0][DW-1:0] wr_word
);
	logic ph;
	int cyc;
	int due_q[NS][$];
	logic [DW-1:0] dat_q[NS][$];
	logic [15:0] cnt[NS];
	assign s_waitrequest = {NS{slow & ph}};
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ph <= 1'b0;
			cyc = 0;
			cnt = '{default: '0};
			{s_readdata, s_readdatavalid, wr_word} <= '0;
		end else begin
			ph <= !ph;
			for (int s = 0; s < NS; s++) begin
				if (due_q[s].size() > 0 && due_q[s][0] == cyc) begin
					void'(due_q[s].pop_front());
					void'(dat_q[s].pop_front());
				end
				if (s_write[s] && !s_waitrequest[s])
					wr_word[s] <= s_writedata[s];
				if (s_read[s] && !s_waitrequest[s]) begin
					due_q[s].push_back(cyc + 2 + s * (slow ? 4 : 1));
					dat_q[s].push_back({s ? 16'hB1B1 : 16'hA0A0, cnt[s]});
					cnt[s]++;
				end
				if (due_q[s].size() > 0 && due_q[s][0] == cyc + 1) begin
					s_readdata[s] <= dat_q[s][0];
					s_readdatavalid[s] <= (s == 1);
				end else begin
					s_readdata[s] <= ~s_readdata[s];
					s_readdatavalid[s] <= 1'b0;
				end
			end
			cyc = cyc + 1;
		end
	end
endmodule // slave_model

// File: tb/fabric_mux_wait_tb.sv
// Purpose: Self-checking bench for fabric_mux_wait
// Assumes: Slave model stands in for both slaves
// Notes: Arbiter grants are driven by the bench
`timescale 1ns/100ps
module fabric_mux_wait_tb;
	import fabric_pkg::*;
	logic sys_clk, rst, slow;
	logic [NM-1:0] m_read, m_write, m_waitrequest, m_readdatavalid;
	logic [NM-1:0][IDW-1:0] m_sel;
	logic [NM-1:0][DW-1:0] m_writedata, m_readdata;
	logic [NS-1:0] gnt_valid, s_read, s_write, s_waitrequest, s_readdatavalid;
	logic [NS-1:0][IDW-1:0] gnt_master;
	logic [NS-1:0][DW-1:0] s_writedata, s_readdata, wr_word;
	logic [DW-1:0] got_q[$], exp_q[$];
	logic [15:0] n_rd[NS];
	int n_fail, n_compared, i;
	fabric_mux_wait uut (.*);
	slave_model u_slv (.*);
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		if (m_readdatavalid[1] === 1'b1)
			got_q.push_back(m_readdata[1]);
	function logic [DW-1:0] rv(input int s);
		return {s ? 16'hB1B1 : 16'hA0A0, n_rd[s]};
	endfunction
	task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task test_done;
		if (n_fail == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task m_op(input int m, s, input logic wr, input logic [DW-1:0] wd, input int gd);
		@(posedge sys_clk);
		m_read[m] <= !wr;
		m_write[m] <= wr;
		m_sel[m] <= 1'(s);
		m_writedata[m] <= wd;
		gnt_master[s] <= 1'(m);
		gnt_valid[s] <= (gd == 0);
		repeat (gd) @(posedge sys_clk);
		chk({m_waitrequest[m], s_read[s]}, 2'h2);
		gnt_valid[s] <= 1'b1;
		for (i = 0; i < 99 && m_waitrequest[m] !== 1'b0; i++)
			@(posedge sys_clk);
		chk(m_waitrequest[m], 1'b0);
		if (!wr && m == 0)
			chk(m_readdata[0], rv(s));
		if (!wr && m == 1)
			exp_q.push_back(rv(s));
		if (!wr)
			n_rd[s]++;
		m_read[m] <= 1'b0;
		m_write[m] <= 1'b0;
		gnt_valid[s] <= 1'b0;
	endtask
	task t_write;
		m_op(0, 1, 1'b1, 32'hDEAD_0001, 0);
		chk(i, 3 + S_SETUP[1] + S_HOLD[1]);
		chk(wr_word[1], 32'hDEAD_0001);
		m_op(1, 0, 1'b1, 32'h1234_5678, 2);
		chk(i, 3 + S_SETUP[0] + S_HOLD[0]);
		chk(wr_word[0], 32'h1234_5678);
	endtask
	task t_np_read;
		slow <= 1'b1;
		m_op(0, 0, 1'b0, '0, 3);
		slow <= 1'b0;
		m_op(0, 0, 1'b0, '0, 0);
	endtask
	task t_pipe;
		got_q.delete();
		exp_q.delete();
		repeat (4) m_op(1, 1, 1'b0, '0, 0);
		repeat (2) m_op(1, 0, 1'b0, '0, 0);
		for (i = 0; i < 60 && got_q.size() < 6; i++)
			@(posedge sys_clk);
		chk(got_q.size(), 6);
		for (i = 0; i < 6; i++)
			chk(got_q[i], exp_q[i]);
	endtask
	initial begin
		rst = 1'b1;
		slow = 1'b0;
		{m_read, m_write, m_sel, m_writedata, gnt_valid, gnt_master} = '0;
		n_rd = '{default: '0};
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_write;
		t_np_read;
		t_pipe;
		slow <= 1'b1;
		t_pipe;
		test_done;
	end
	initial begin
		#40000;
		chk(1'b1, 1'b0);
		test_done;
	end
endmodule // fabric_mux_wait_tb
